// ==== adtrg_pkg.sv ====
// Purpose: shared constants and types of the converter trigger and result block
// Assumes: byte registers sit in the low bits of 32-bit APB words
// Notes: register indices times four give the byte addresses
package adtrg_pkg;
    localparam int ADTRG_RES_W = 10;
    localparam int ADTRG_BYTE_W = 8;
    localparam int ADTRG_DATA_W = 32;
    localparam int ADTRG_ADDR_W = 8;
    localparam int ADTRG_IDX_W = 6;
    localparam int ADTRG_EV_W = 2;
    localparam int ADTRG_SYNC_W = 2;
    // register indices
    localparam logic [5:0] ADTRG_IDX_DID = 6'h17;
    localparam logic [5:0] ADTRG_IDX_RESL = 6'h19;
    localparam logic [5:0] ADTRG_IDX_RESH = 6'h1a;
    localparam logic [5:0] ADTRG_IDX_CTLB = 6'h1c;
    localparam logic [5:0] ADTRG_IDX_CTLA = 6'h1d;
    localparam logic [5:0] ADTRG_IDX_STS = 6'h20;
    localparam logic [5:0] ADTRG_IDX_MSK = 6'h21;
    // converter_control_a fields
    localparam int ADTRG_A_EN = 7;
    localparam int ADTRG_A_START = 6;
    localparam int ADTRG_A_AUTO = 5;
    localparam int ADTRG_A_FLAG = 4;
    localparam int ADTRG_A_IE = 3;
    localparam int ADTRG_A_PSC_HI = 2;
    // converter_control_b fields
    localparam int ADTRG_B_LADJ = 7;
    localparam int ADTRG_B_SEL_HI = 2;
    // status and mask fields
    localparam int ADTRG_EV_DONE = 0;
    localparam int ADTRG_EV_TRIG = 1;
    localparam logic [7:0] ADTRG_RST_BYTE = 8'h00;
    localparam logic [5:0] ADTRG_PAD6 = 6'h00;
    localparam logic [3:0] ADTRG_PAD4 = 4'h0;
    typedef enum logic [2:0] {
        ADTRG_SRC_FREE = 3'b000,
        ADTRG_SRC_CMP = 3'b001,
        ADTRG_SRC_EXT0 = 3'b010,
        ADTRG_SRC_T0CA = 3'b011,
        ADTRG_SRC_T0OV = 3'b100,
        ADTRG_SRC_T0CB = 3'b101,
        ADTRG_SRC_PCH0 = 3'b110,
        ADTRG_SRC_T0CAP = 3'b111
    } adtrg_src_t;
    typedef enum logic [1:0] {
        ADTRG_BUS_IDLE = 2'b01,
        ADTRG_BUS_ACK = 2'b10
    } adtrg_bus_t;
endpackage : adtrg_pkg

// ==== adtrg_top.sv ====
// Purpose: converter auto trigger, result byte views and input disable over APB
// Assumes: analog core pulses conv_done with conv_result valid in that cycle
// Notes: every access takes one wait state; pready and prdata come from flops
//
// Summary of operation
// - trigger select matters only while auto trigger is enabled.
// - auto trigger starts a conversion on rising edge of selected flag.
// - switching from a low source to a high source counts as edge.
// - selecting free running never causes a trigger by itself.
// - codes 000..111: free, comparator, ext0, cmpA, ovf, cmpB, pinchg, capture.
// - right adjusted low byte returns result bits 7..0, reset zero.
// - right adjusted high byte returns bits 9..8 in 1..0, upper zero.
// - left adjusted low byte returns bits 1..0 in 7..6, lower zero.
// - left adjusted high byte returns result bits 9..2, reset zero.
// - each input disable bit blocks its pin; pin reads zero.
// - disable bits 0 and 1 also gate comparator pins; others do not.
// - auto trigger enable allows hardware starts; clear leaves software starts.
// - completion flag sets on finish; cleared by vector or writing one.
// - reading low byte locks results until the high byte is read.
// - left adjust change alters byte views at once.
`timescale 1ns/1ps
module adtrg_top
    import adtrg_pkg::*;
#(
    parameter int PINS = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADTRG_ADDR_W-1:0] paddr,
    input wire logic [ADTRG_DATA_W-1:0] pwdata,
    output logic [ADTRG_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:1] trig_flags,
    input wire logic conv_done,
    input wire logic [ADTRG_RES_W-1:0] conv_result,
    input wire logic int_ack,
    input wire logic [PINS-1:0] pin_in,
    output logic conv_start,
    output logic conv_enable,
    output logic conv_busy,
    output logic [2:0] prescale_sel,
    output logic [PINS-1:0] pin_read,
    output logic [PINS-1:0] pin_buffer_off,
    output logic cmp_read_pos,
    output logic cmp_read_neg,
    output logic irq
);
    if (PINS < 2 || PINS > ADTRG_BYTE_W) begin : g_bad_pins
        $error("PINS must lie between 2 and 8");
    end

    ////////////////////////////////////////////////////////////////////////////
    adtrg_bus_t state_q;
    adtrg_bus_t state_d;
    logic [ADTRG_DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [PINS-1:0] did_q;
    logic en_q;
    logic auto_q;
    logic flag_q;
    logic busy_q;
    logic [2:0] psc_q;
    logic ladj_q;
    adtrg_src_t sel_q;
    logic [ADTRG_EV_W-1:0] sts_q;
    logic [ADTRG_EV_W-1:0] mask_q;
    logic [ADTRG_RES_W-1:0] res_q;
    logic lock_q;
    logic start_q;
    logic irq_q;
    logic [PINS-1:0] sync1_q;
    logic [PINS-1:0] sync2_q;
    logic [PINS-1:0] pin_read_q;
    logic cmp_pos_q;
    logic cmp_neg_q;

    logic [ADTRG_IDX_W-1:0] idx;
    logic access;
    logic commit;
    logic wr;
    logic rd;
    logic sel_did;
    logic sel_resl;
    logic sel_resh;
    logic sel_ctla;
    logic sel_ctlb;
    logic sel_sts;
    logic sel_msk;
    logic hit;
    logic [ADTRG_BYTE_W-1:0] res_lo;
    logic [ADTRG_BYTE_W-1:0] res_hi;
    logic [ADTRG_BYTE_W-1:0] ctla_rd;
    logic [ADTRG_BYTE_W-1:0] ctlb_rd;
    logic [ADTRG_BYTE_W-1:0] byte_rd;
    logic wr_ctla;
    logic en_next;
    logic sw_start;
    logic start_ok;
    logic busy_d;
    logic flag_clr;
    logic flag_d;
    logic [ADTRG_EV_W-1:0] ev_set;
    logic [ADTRG_EV_W-1:0] sts_clr;
    logic [ADTRG_EV_W-1:0] sts_d;
    logic rd_low;
    logic rd_high;
    logic lock_d;
    logic res_load;
    adtrg_trig_if tif ();

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    assign idx = paddr[ADTRG_ADDR_W-1:2];
    assign access = psel & penable;
    assign commit = access & (state_q == ADTRG_BUS_ACK);
    assign wr = commit & pwrite;
    assign rd = commit & ~pwrite;
    assign sel_did = (idx == ADTRG_IDX_DID);
    assign sel_resl = (idx == ADTRG_IDX_RESL);
    assign sel_resh = (idx == ADTRG_IDX_RESH);
    assign sel_ctla = (idx == ADTRG_IDX_CTLA);
    assign sel_ctlb = (idx == ADTRG_IDX_CTLB);
    assign sel_sts = (idx == ADTRG_IDX_STS);
    assign sel_msk = (idx == ADTRG_IDX_MSK);
    assign hit = sel_did | sel_resl | sel_resh | sel_ctla | sel_ctlb | sel_sts | sel_msk;

    // views follow ladj_q with no storage, so a change shows at once
    assign res_lo = ladj_q ? {res_q[1:0], ADTRG_PAD6} : res_q[7:0];
    assign res_hi = ladj_q ? res_q[9:2] : {ADTRG_PAD6, res_q[9:8]};
    assign ctla_rd = {en_q, busy_q, auto_q, flag_q, mask_q[ADTRG_EV_DONE], psc_q};
    assign ctlb_rd = {ladj_q, ADTRG_PAD4, sel_q};
    assign byte_rd = sel_did ? {{(ADTRG_BYTE_W-PINS){1'b0}}, did_q} :
                     sel_resl ? res_lo :
                     sel_resh ? res_hi :
                     sel_ctla ? ctla_rd :
                     sel_ctlb ? ctlb_rd :
                     sel_sts ? {ADTRG_PAD6, sts_q} :
                     sel_msk ? {ADTRG_PAD6, mask_q} : ADTRG_RST_BYTE;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ADTRG_BUS_IDLE: begin
                if (access) begin
                    state_d = ADTRG_BUS_ACK;
                end
            end
            ADTRG_BUS_ACK: begin
                state_d = ADTRG_BUS_IDLE;
            end
            default: begin
                state_d = ADTRG_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ADTRG_BUS_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            state_q <= state_d;
            pready_q <= (state_d == ADTRG_BUS_ACK);
            // data captured on the same edge that raises pready, held through the ack cycle
            if (access && state_q == ADTRG_BUS_IDLE) begin
                pslverr_q <= ~hit;
                prdata_q <= {{(ADTRG_DATA_W-ADTRG_BYTE_W){1'b0}}, byte_rd};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers and conversion start
    assign wr_ctla = wr & sel_ctla;
    assign en_next = wr_ctla ? pwdata[ADTRG_A_EN] : en_q;
    assign sw_start = wr_ctla & pwdata[ADTRG_A_START] & pwdata[ADTRG_A_EN];
    // starts dropped while busy, except in the completion cycle (free running restart)
    assign start_ok = (sw_start | tif.fire) & (~busy_q | conv_done) & en_next;
    // disabling the converter aborts a running conversion
    assign busy_d = en_next & (start_ok | (busy_q & ~conv_done));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            auto_q <= 1'b0;
            psc_q <= '0;
            ladj_q <= 1'b0;
            sel_q <= ADTRG_SRC_FREE;
            did_q <= '0;
            mask_q <= '0;
        end else begin
            if (wr_ctla) begin
                en_q <= pwdata[ADTRG_A_EN];
                auto_q <= pwdata[ADTRG_A_AUTO];
                psc_q <= pwdata[ADTRG_A_PSC_HI:0];
            end
            if (wr & sel_ctlb) begin
                ladj_q <= pwdata[ADTRG_B_LADJ];
                sel_q <= adtrg_src_t'(pwdata[ADTRG_B_SEL_HI:0]);
            end
            if (wr & sel_did) begin
                did_q <= pwdata[PINS-1:0];
            end
            if (wr & sel_msk) begin
                mask_q <= pwdata[ADTRG_EV_W-1:0];
            end else if (wr_ctla) begin
                mask_q[ADTRG_EV_DONE] <= pwdata[ADTRG_A_IE];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
            start_q <= start_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger edge detector
    assign tif.sel = sel_q;
    assign tif.auto_en = auto_q;
    assign tif.conv_en = en_q;
    assign tif.done = conv_done;
    assign tif.flags = trig_flags;

    adtrg_trig u_trig (
        .pclk(pclk),
        .presetn(presetn),
        .tif(tif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // completion flag, status and interrupt; set wins over any clear
    assign flag_clr = (wr_ctla & pwdata[ADTRG_A_FLAG]) | int_ack
        | (wr & sel_sts & pwdata[ADTRG_EV_DONE]);
    assign flag_d = (flag_q & ~flag_clr) | conv_done;
    assign ev_set = {start_ok & tif.fire, conv_done};
    assign sts_clr = (wr & sel_sts) ? pwdata[ADTRG_EV_W-1:0] : '0;
    assign sts_d = {(sts_q[ADTRG_EV_TRIG] & ~sts_clr[ADTRG_EV_TRIG]) | ev_set[ADTRG_EV_TRIG],
        flag_d};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
            sts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            sts_q <= sts_d;
            irq_q <= |(sts_d & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result store with low-then-high read lock
    assign rd_low = rd & sel_resl;
    assign rd_high = rd & sel_resh;
    // a result finishing while locked is lost, never mixed into a half-read pair
    assign res_load = conv_done & ~lock_q;
    assign lock_d = (lock_q | rd_low) & ~rd_high;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_q <= '0;
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_d;
            if (res_load) begin
                res_q <= conv_result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin inputs: two-stage synchroniser, then disable gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            pin_read_q <= '0;
            cmp_pos_q <= 1'b0;
            cmp_neg_q <= 1'b0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            pin_read_q <= sync2_q & ~did_q;
            // only the two lowest bits reach the comparator pins
            cmp_pos_q <= sync2_q[0] & ~did_q[0];
            cmp_neg_q <= sync2_q[1] & ~did_q[1];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign conv_start = start_q;
    assign conv_enable = en_q;
    assign conv_busy = busy_q;
    assign prescale_sel = psc_q;
    assign pin_read = pin_read_q;
    assign pin_buffer_off = did_q;
    assign cmp_read_pos = cmp_pos_q;
    assign cmp_read_neg = cmp_neg_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [7:0] chk_src;
    logic chk_flag;
    logic chk_prev_q;
    logic rd_setup;
    assign chk_src = {trig_flags, 1'b0};
    assign chk_flag = (sel_q == ADTRG_SRC_FREE) ? 1'b0 : chk_src[sel_q];
    assign rd_setup = access & ~pwrite & (state_q == ADTRG_BUS_IDLE);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_prev_q <= 1'b0;
        end else begin
            chk_prev_q <= chk_flag;
        end
    end

    a_auto_off_quiet: assert property (!auto_q && !sw_start |=> !conv_start)
        else $error("trigger fired with auto trigger off");
    a_rise_fires: assert property (auto_q && en_q && chk_flag && !chk_prev_q |-> tif.fire)
        else $error("rising selected flag did not fire");
    a_fire_starts: assert property (tif.fire && !busy_q && !wr |=> conv_start ##1 !conv_start)
        else $error("fire did not give a one-cycle start");
    a_free_quiet: assert property (sel_q == ADTRG_SRC_FREE && !conv_done |-> !tif.fire)
        else $error("free running fired without completion");
    a_right_low: assert property (rd_setup && sel_resl && !ladj_q |=>
        prdata[7:0] == $past(res_q[7:0]))
        else $error("right adjusted low byte wrong");
    a_right_high: assert property (rd_setup && sel_resh && !ladj_q |=>
        prdata[7:0] == {ADTRG_PAD6, $past(res_q[9:8])})
        else $error("right adjusted high byte wrong");
    a_left_low: assert property (rd_setup && sel_resl && ladj_q |=>
        prdata[7:0] == {$past(res_q[1:0]), ADTRG_PAD6})
        else $error("left adjusted low byte wrong");
    a_left_high: assert property (rd_setup && sel_resh && ladj_q |=>
        prdata[7:0] == $past(res_q[9:2]))
        else $error("left adjusted high byte wrong");
    a_pin_gated: assert property (1'b1 |=> (pin_read & $past(did_q)) == '0)
        else $error("disabled pin read as one");
    a_cmp_gated: assert property (did_q[1] |=> !cmp_read_neg)
        else $error("disabled comparator pin read as one");
    a_flag_set: assert property (conv_done |=> flag_q ##1 (flag_q || $past(flag_clr)))
        else $error("completion flag not set");
    a_lock_hold: assert property (lock_q && !rd_high |=> lock_q && $stable(res_q))
        else $error("locked result changed");
    a_ladj_now: assert property ($changed(ladj_q) |->
        {res_hi, res_lo} == (ladj_q ? {res_q, ADTRG_PAD6} : {ADTRG_PAD6, res_q}))
        else $error("byte view lagged adjust change");

    c_hw_start: cover property (tif.fire ##1 conv_start);
    c_locked_drop: cover property (lock_q && conv_done);
    c_sw_start: cover property (sw_start ##1 conv_busy);
    c_irq: cover property (irq && conv_done);
endmodule : adtrg_top

// ==== adtrg_trig.sv ====
// Purpose: rising-edge detector on the selected trigger flag
// Assumes: event flags come from logic on pclk, so no synchroniser
// Notes: fire is combinational, the top registers the start
`timescale 1ns/1ps
module adtrg_trig
    import adtrg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    adtrg_trig_if.trg tif
);
    logic [7:0] src_vec;
    logic sel_flag;
    logic prev_q;
    logic edge_w;
    logic free_w;

    // free running code sees a constant low, so switching to it never rises
    assign src_vec = {tif.flags, 1'b0};
    assign free_w = (tif.sel == ADTRG_SRC_FREE);
    assign sel_flag = free_w ? 1'b0 : src_vec[tif.sel];
    // a source change moves sel_flag too, so low-to-high switch reads as an edge
    assign edge_w = sel_flag & ~prev_q;
    // free running restarts on each completion
    assign tif.fire = tif.auto_en & tif.conv_en & (edge_w | (free_w & tif.done));

    // sampled every clock, whether or not auto trigger is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sel_flag;
        end
    end
endmodule : adtrg_trig

// ==== adtrg_trig_if.sv ====
// Purpose: carries trigger controls and the fire strobe between top and edge detector
// Assumes: single pclk domain
// Notes: flags index 1..7 match the trigger source codes
`timescale 1ns/1ps
interface adtrg_trig_if;
    import adtrg_pkg::*;
    adtrg_src_t sel;
    logic auto_en;
    logic conv_en;
    logic done;
    logic [7:1] flags;
    logic fire;
    modport ctl (output sel, output auto_en, output conv_en, output done, output flags,
        input fire);
    modport trg (input sel, input auto_en, input conv_en, input done, input flags,
        output fire);
endinterface : adtrg_trig_if

// ==== tb_adc_trigger_and_result_regs.sv ====
// Purpose: self-checking bench for the converter trigger and result block over APB
// Assumes: pready answers within a few cycles; pin_read settles within 3 cycles
// Notes: bench stands in for the analog core, event flags and pads
`timescale 1ns/1ps
module tb_adc_trigger_and_result_regs;
    import adtrg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [7:1] trig_flags;
    logic conv_done, int_ack, conv_start, conv_enable, conv_busy, cmp_read_pos, cmp_read_neg, irq;
    logic [9:0] conv_result;
    logic [7:0] pin_in, pin_read, pin_buffer_off, dv;
    logic [2:0] prescale_sel;
    logic err_v;
    int err_total = 0;
    int n_tests = 0;
    int n_starts = 0;
    int s_base = 0;
    logic [7:0] did_tab [3] = '{8'ha5, 8'hfc, 8'h03};

    adtrg_top #(.PINS(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_flags(trig_flags),
        .conv_done(conv_done), .conv_result(conv_result), .int_ack(int_ack),
        .pin_in(pin_in), .conv_start(conv_start), .conv_enable(conv_enable),
        .conv_busy(conv_busy), .prescale_sel(prescale_sel), .pin_read(pin_read),
        .pin_buffer_off(pin_buffer_off), .cmp_read_pos(cmp_read_pos),
        .cmp_read_neg(cmp_read_neg), .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // start pulses are counted here so scenarios can check exact deltas
    always @(posedge pclk) begin
        if (conv_start === 1'b1) n_starts++;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp, input string nm);
        apb(1'b0, idx, 32'h0000_0000);
        chk(nm, exp, rd_v);
    endtask : rdc

    task automatic starts(input int exp);
        chk("start_count", exp, n_starts - s_base);
        s_base = n_starts;
    endtask : starts

    // one-cycle pulse on conv_done or int_ack, then two settle edges
    task automatic pulse(input logic ack, input logic [9:0] res);
        @(posedge pclk);
        conv_done <= ~ack;
        int_ack <= ack;
        conv_result <= res;
        @(posedge pclk);
        conv_done <= 1'b0;
        int_ack <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : pulse

    // software start with irq enable, then the core reports the result
    task automatic convert(input logic [9:0] res);
        apb(1'b1, ADTRG_IDX_CTLA, 32'h0000_00c8);
        repeat (3) @(posedge pclk);
        pulse(1'b0, res);
    endtask : convert

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, conv_done, int_ack} = 5'b0_0000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        trig_flags = 7'h00;
        conv_result = 10'h000;
        pin_in = 8'hff;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(ADTRG_IDX_DID, 32'h0000_0000, "did_reset");
        rdc(ADTRG_IDX_RESL, 32'h0000_0000, "resl_reset");
        rdc(ADTRG_IDX_RESH, 32'h0000_0000, "resh_reset");
        rdc(6'h05, 32'h0000_0000, "unmapped_data");
        chk("unmapped_err", 32'h1, {31'h0, err_v});
        // pad gating, comparator pins follow bits 0 and 1 only
        for (int i = 0; i < 3; i++) begin
            dv = did_tab[i];
            apb(1'b1, ADTRG_IDX_DID, {24'h00_0000, dv});
            rdc(ADTRG_IDX_DID, {24'h00_0000, dv}, "did_rw");
            repeat (5) @(posedge pclk);
            chk("buffer_off", {24'h0, dv}, {24'h0, pin_buffer_off});
            chk("pin_read", {24'h0, ~dv}, {24'h0, pin_read});
            chk("cmp_pos", {31'h0, ~dv[0]}, {31'h0, cmp_read_pos});
            chk("cmp_neg", {31'h0, ~dv[1]}, {31'h0, cmp_read_neg});
        end
        apb(1'b1, ADTRG_IDX_MSK, 32'h0000_0001);
        convert(10'h2b5);
        starts(1);
        chk("irq_set", 32'h1, {31'h0, irq});
        rdc(ADTRG_IDX_CTLA, 32'h0000_0098, "ctla_flag");
        rdc(ADTRG_IDX_RESL, 32'h0000_00b5, "resl_right");
        rdc(ADTRG_IDX_RESH, 32'h0000_0002, "resh_right");
        apb(1'b1, ADTRG_IDX_CTLB, 32'h0000_0080);
        rdc(ADTRG_IDX_RESL, 32'h0000_0040, "resl_left");
        rdc(ADTRG_IDX_RESH, 32'h0000_00ad, "resh_left");
        apb(1'b1, ADTRG_IDX_STS, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("irq_w1c", 32'h0, {31'h0, irq});
        // half-read result must survive a new conversion
        rdc(ADTRG_IDX_RESL, 32'h0000_0040, "resl_lock");
        convert(10'h155);
        rdc(ADTRG_IDX_RESH, 32'h0000_00ad, "resh_locked");
        convert(10'h155);
        rdc(ADTRG_IDX_RESL, 32'h0000_0040, "resl_new");
        rdc(ADTRG_IDX_RESH, 32'h0000_0055, "resh_new");
        pulse(1'b1, 10'h000);
        chk("irq_ack", 32'h0, {31'h0, irq});
        s_base = n_starts;
        // selection ignored while auto trigger is off
        apb(1'b1, ADTRG_IDX_CTLB, 32'h0000_0001);
        apb(1'b1, ADTRG_IDX_CTLA, 32'h0000_0080);
        trig_flags <= 7'h01;
        repeat (4) @(posedge pclk);
        trig_flags <= 7'h00;
        repeat (4) @(posedge pclk);
        starts(0);
        for (int c = 1; c < 8; c++) begin
            apb(1'b1, ADTRG_IDX_CTLB, c);
            apb(1'b1, ADTRG_IDX_CTLA, 32'h0000_00a0);
            trig_flags <= ~(7'h01 << (c - 1));
            repeat (4) @(posedge pclk);
            starts(0);
            trig_flags <= 7'h7f;
            repeat (4) @(posedge pclk);
            starts(1);
            pulse(1'b0, 10'h000);
            trig_flags <= 7'h00;
            repeat (2) @(posedge pclk);
        end
        apb(1'b1, ADTRG_IDX_CTLB, 32'h0000_0001);
        trig_flags <= 7'h02;
        repeat (4) @(posedge pclk);
        starts(0);
        apb(1'b1, ADTRG_IDX_CTLB, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        starts(1);
        pulse(1'b0, 10'h000);
        trig_flags <= 7'h00;
        // completion flag is set here, switching to free running must stay quiet
        apb(1'b1, ADTRG_IDX_CTLB, 32'h0000_0000);
        repeat (4) @(posedge pclk);
        starts(0);
        pulse(1'b0, 10'h000);
        starts(1);
        // completion while busy must restart at once in free running
        pulse(1'b0, 10'h000);
        starts(1);
        chk("en_busy", 32'h3, {30'h0, conv_enable, conv_busy});
        apb(1'b1, ADTRG_IDX_CTLA, 32'h0000_0080);
        pulse(1'b0, 10'h000);
        starts(0);
        apb(1'b1, ADTRG_IDX_CTLA, 32'h0000_0005);
        chk("psc_off", 32'h5, {27'h0, conv_enable, conv_busy, prescale_sel});
        tally_and_finish();
    end
endmodule : tb_adc_trigger_and_result_regs
